// *** rtl/lcd_driver_controller.sv ***
// Display controller: register file, frame timing, panel streaming, RAM map.
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/1ps
`include "lcd_cfg.svh"

// Notes on behaviour
// [R1] Software writes ones to the top three bits of the second control.
// [R2] Sequential map: image address raises matching enable; A0 picks data.
// [R3] Pairs map to shift, latch, frame, cascade pins; instruction first.
// [R4] Image addresses are external area, so read/write strobes fire too.
// [R5] Random map: four 64 KB regions enable drivers one to four.
// [R6] Direct-RAM select bit picks sequential or random address map.
// [R7] Software sets mode, start address and size before start.
// [R8] Started, request the bus, read memory, send one panel of data.
// [R9] Pins follow each transfer; drop the bus request when done.
// [R10] Frame, cascade and latch pulses derive from the LCD source clock.
// [R11] Source clock is oscillator or timer 3; select resets to oscillator.
// [R12] Each frame gives one cascade pulse and inverts the frame pin.
// [R13] Nine-bit frame count: bit 8 in main control, rest in low register.
// [R14] Latch period is D source counts; frame is D times frame count.
// [R15] Software keeps frame count between common number and the limit.
// [R16] Main control: display on, width, direct RAM, count bit 8, start.
// [R17] Driver commands are only written through the controller, never read; CPU reads at A0-low map addresses still raise ext_rd_o.
// [R18] Start bit clear after reset; bus request idle until started.
module lcd_driver_controller
    import lcd_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int FIFO_WIDTH = 16
) (
    input wire logic clk_i, // System clock, 10 MHz.
    input wire logic resetn_i, // Synchronous reset, active low.
    input wire logic [`REG_ADDR_W-1:0] reg_addr_i, // Register address.
    input wire logic [7:0] reg_wdata_i, // Register write data.
    input wire logic reg_wr_i, // Register write strobe.
    input wire logic reg_rd_i, // Register read strobe.
    output logic [7:0] reg_rdata_o, // Read data, cycle after strobe.
    input wire logic lcd_osc_i, // Low-frequency oscillator level.
    input wire logic timer3_output_i, // Timer 3 output level.
    input wire logic [23:0] cpu_addr_i, // CPU access address.
    input wire logic cpu_rd_i, // CPU read access.
    input wire logic cpu_wr_i, // CPU write access.
    output logic ext_rd_o, // External read strobe, active high.
    output logic ext_wr_o, // External write strobe, active high.
    output logic a0_o, // Instruction (0) or display data (1).
    output logic bus_req_o, // Bus release request to CPU.
    input wire logic bus_ack_i, // Bus granted by CPU.
    output logic [23:0] mem_addr_o, // Source memory address.
    output logic mem_rd_o, // Source memory read pulse.
    input wire logic [15:0] mem_data_i, // Source memory read data.
    input wire logic mem_valid_i, // Read data valid pulse.
    output logic [7:0] lcd_data_o, // Data to column driver.
    output logic shift_clock_pin_o, // Shift clock or enable 1.
    output logic latch_pulse_pin_o, // Latch pulse or enable 2.
    output logic frame_pin_o, // Frame level or enable 3.
    output logic cascade_pin_o, // Cascade pulse or enable 4.
    output logic display_off_pin_o // Low means display off.
);
    fifo_if #(.WIDTH(FIFO_WIDTH)) fq ();

    logic [7:0] start_low_q, start_high_q, panel_size_q;
    logic [7:0] main_ctl_q, frame_low_q, second_ctl_q;
    logic timer_clock_select_q;
    logic [7:0] reg_rdata_q;
    xfer_state_t state_q;
    logic bus_req_q, mem_rd_q;
    logic [23:0] mem_addr_q;
    logic [13:0] reads_left_q, bytes_sent_q;
    logic src_q;
    logic [3:0] half_q;
    logic [8:0] line_q;
    logic latch_lvl_q, cascade_lvl_q, frame_lvl_q;
    logic latch_ev, frame_ev, src_edge, src_now;
    logic sh_busy_q, sh_phase_q, sh_hi_q, sh_clk_q;
    logic [7:0] sh_byte_q, sh_next_q, sh_out_q;
    logic [3:0] sh_units_q;
    logic byte_done;
    logic [3:0] pins_q;
    logic a0_q, ext_rd_q, ext_wr_q;

    wire logic sr_mode = start_low_q[`MODE_SEL_BIT];
    wire logic start = main_ctl_q[`START_BIT];
    wire logic word_mode = second_ctl_q[`RAM_WIDTH_BIT];
    wire width_mode_t wmode = width_mode_t'(
        {main_ctl_q[`WIDTH_HI_BIT], main_ctl_q[`WIDTH_LO_BIT]}); // [R16]
    wire logic [8:0] frame_count = {main_ctl_q[`FRAME_BIT8_BIT],
                                    frame_low_q}; // [R13]

    // Common lines for the size code; reserved codes fall back to 64.
    function automatic logic [8:0] com_lines(input logic [3:0] c);
        case (c)
            4'h1: com_lines = 9'd68;
            4'h2: com_lines = 9'd80;
            4'h3: com_lines = 9'd100;
            4'h4: com_lines = 9'd120;
            4'h5: com_lines = 9'd128;
            4'h6: com_lines = 9'd144;
            4'h7: com_lines = 9'd160;
            4'h8: com_lines = 9'd200;
            4'h9: com_lines = 9'd240;
            default: com_lines = 9'd64;
        endcase
    endfunction

    function automatic logic [8:0] seg_cols(input logic [3:0] c);
        case (c)
            4'h1: seg_cols = 9'd64;
            4'h2: seg_cols = 9'd80;
            4'h3: seg_cols = 9'd120;
            4'h4: seg_cols = 9'd128;
            4'h5: seg_cols = 9'd160;
            4'h6: seg_cols = 9'd240;
            4'h7: seg_cols = 9'd320;
            4'h8: seg_cols = 9'd360;
            default: seg_cols = 9'd32;
        endcase
    endfunction

    // Latch period D counted in half source-clock periods (2 x D).
    function automatic logic [3:0] d_halves(input logic [3:0] c);
        case (c)
            4'h1: d_halves = 4'd12;
            4'h2: d_halves = 4'd10;
            4'h3: d_halves = 4'd8;
            4'h4: d_halves = 4'd7;
            4'h5: d_halves = 4'd6;
            4'h6: d_halves = 4'd5;
            4'h7: d_halves = 4'd5;
            4'h8: d_halves = 4'd4;
            4'h9: d_halves = 4'd3;
            default: d_halves = 4'd13;
        endcase
    endfunction

    function automatic logic [3:0] units_per_byte(input width_mode_t m);
        case (m)
            WIDTH_NIBBLE: units_per_byte = 4'd2;
            WIDTH_BIT: units_per_byte = 4'd8;
            default: units_per_byte = 4'd1;
        endcase
    endfunction

    logic [17:0] panel_pixels;
    logic [13:0] total_bytes, total_reads;
    assign panel_pixels = com_lines(panel_size_q[7:4]) *
                          seg_cols(panel_size_q[3:0]);
    assign total_bytes = panel_pixels[16:3];
    assign total_reads = word_mode ? 14'(({1'b0, total_bytes} + 15'd1) >> 1)
                                   : total_bytes;

    // Register writes. Bits of the second control above the used fields
    // are kept as written; software is expected to write them as ones.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            start_low_q <= `RST_BYTE;
            start_high_q <= `RST_BYTE;
            panel_size_q <= `RST_BYTE;
            main_ctl_q <= `RST_BYTE; // [R18]
            frame_low_q <= `RST_BYTE;
            second_ctl_q <= `RST_BYTE; // [R1]
            timer_clock_select_q <= 1'b0; // [R11]
        end else if (reg_wr_i) begin
            case (reg_addr_i)
                `OFS_START_LOW: start_low_q <= reg_wdata_i;
                `OFS_START_HIGH: start_high_q <= reg_wdata_i;
                `OFS_PANEL_SIZE: panel_size_q <= reg_wdata_i;
                `OFS_MAIN_CTL: main_ctl_q <= reg_wdata_i; // [R16]
                `OFS_FRAME_LOW: frame_low_q <= reg_wdata_i; // [R13]
                `OFS_SECOND_CTL: second_ctl_q <= reg_wdata_i;
                `OFS_CLK_STATUS: begin
                    timer_clock_select_q <= reg_wdata_i[`TIMER_SEL_BIT];
                end
                default: ;
            endcase
        end
    end

    // Register reads, answered in the following cycle.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            reg_rdata_q <= `RST_BYTE;
        end else if (reg_rd_i) begin
            case (reg_addr_i)
                `OFS_START_LOW: reg_rdata_q <= start_low_q;
                `OFS_START_HIGH: reg_rdata_q <= start_high_q;
                `OFS_PANEL_SIZE: reg_rdata_q <= panel_size_q;
                `OFS_MAIN_CTL: reg_rdata_q <= main_ctl_q;
                `OFS_FRAME_LOW: reg_rdata_q <= frame_low_q;
                `OFS_SECOND_CTL: reg_rdata_q <= second_ctl_q;
                `OFS_CLK_STATUS: reg_rdata_q <= {6'h00, bus_req_q,
                                                 timer_clock_select_q};
                default: reg_rdata_q <= `RST_BYTE;
            endcase
        end else begin
            reg_rdata_q <= `RST_BYTE;
        end
    end

    // Every level change of the chosen source is one half period.
    assign src_now = timer_clock_select_q ? timer3_output_i
                                          : lcd_osc_i; // [R11]
    assign src_edge = src_now != src_q; // [R10]
    assign latch_ev = src_edge &&
                      (half_q == d_halves(panel_size_q[7:4]) - 4'd1); // [R14]
    assign frame_ev = latch_ev &&
                      (line_q + 9'd1 >= frame_count); // [R14]

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            src_q <= 1'b0;
            half_q <= '0;
            line_q <= '0;
            latch_lvl_q <= 1'b0;
            cascade_lvl_q <= 1'b0;
            frame_lvl_q <= 1'b0;
        end else begin
            src_q <= src_now;
            if (src_edge) begin
                half_q <= latch_ev ? 4'd0 : half_q + 4'd1;
                latch_lvl_q <= latch_ev; // [R10]
                cascade_lvl_q <= frame_ev; // [R12]
            end
            if (latch_ev) begin
                line_q <= frame_ev ? 9'd0 : line_q + 9'd1; // [R13]
            end
            if (frame_ev) begin
                frame_lvl_q <= !frame_lvl_q; // [R12]
            end
        end
    end

    // Panel fetch: one panel per frame while the start bit and the mode select bit are set.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= XFER_IDLE;
            bus_req_q <= 1'b0; // [R18]
            mem_rd_q <= 1'b0;
            mem_addr_q <= '0;
            reads_left_q <= '0;
        end else begin
            mem_rd_q <= 1'b0;
            case (state_q)
                XFER_IDLE: begin
                    if (start && sr_mode && frame_ev) begin
                        bus_req_q <= 1'b1; // [R8]
                        mem_addr_q <= {start_high_q, start_low_q[7:4],
                                       12'h000};
                        reads_left_q <= total_reads;
                        state_q <= XFER_REQ;
                    end
                end
                XFER_REQ: begin
                    if (bus_ack_i) begin
                        state_q <= XFER_FETCH;
                    end
                end
                XFER_FETCH: begin
                    if (reads_left_q == '0) begin
                        state_q <= XFER_DRAIN;
                    end else if (fq.wready) begin
                        mem_rd_q <= 1'b1; // [R8]
                        state_q <= XFER_WAIT;
                    end
                end
                XFER_WAIT: begin
                    if (mem_valid_i) begin
                        reads_left_q <= reads_left_q - 14'd1;
                        mem_addr_q <= mem_addr_q +
                                      (word_mode ? 24'd2 : 24'd1);
                        state_q <= XFER_FETCH;
                    end
                end
                XFER_DRAIN: begin
                    if (bytes_sent_q == total_bytes) begin
                        bus_req_q <= 1'b0; // [R9]
                        state_q <= XFER_IDLE;
                    end
                end
                default: state_q <= XFER_IDLE;
            endcase
        end
    end

    assign fq.wdata = FIFO_WIDTH'(mem_data_i);
    assign fq.wvalid = (state_q == XFER_WAIT) && mem_valid_i;
    assign fq.rready = !sh_busy_q;

    lcd_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .port_io(fq)
    );

    // Shifter: each unit is set up with the clock high, taken on its fall.
    assign byte_done = sh_busy_q && sh_phase_q && (sh_units_q == 4'd1);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sh_busy_q <= 1'b0;
            sh_phase_q <= 1'b0;
            sh_hi_q <= 1'b0;
            sh_clk_q <= 1'b0;
            sh_byte_q <= '0;
            sh_next_q <= '0;
            sh_out_q <= '0;
            sh_units_q <= '0;
            bytes_sent_q <= '0;
        end else begin
            if (state_q == XFER_IDLE) begin
                bytes_sent_q <= '0;
            end else if (byte_done) begin
                bytes_sent_q <= bytes_sent_q + 14'd1;
            end
            if (!sh_busy_q) begin
                sh_clk_q <= 1'b0;
                if (fq.rvalid) begin
                    sh_busy_q <= 1'b1;
                    sh_phase_q <= 1'b0;
                    sh_byte_q <= fq.rdata[7:0];
                    sh_next_q <= fq.rdata[15:8];
                    sh_hi_q <= word_mode;
                    sh_units_q <= units_per_byte(wmode);
                end
            end else if (!sh_phase_q) begin
                sh_phase_q <= 1'b1;
                sh_clk_q <= 1'b1; // [R9]
                case (wmode)
                    WIDTH_NIBBLE: sh_out_q <= {4'h0, sh_byte_q[7:4]};
                    WIDTH_BIT: sh_out_q <= {7'h00, sh_byte_q[7]};
                    default: sh_out_q <= sh_byte_q;
                endcase
            end else begin
                sh_phase_q <= 1'b0;
                sh_clk_q <= 1'b0; // [R9]
                sh_units_q <= sh_units_q - 4'd1;
                sh_byte_q <= (wmode == WIDTH_NIBBLE) ? {sh_byte_q[3:0], 4'h0}
                                                     : {sh_byte_q[6:0], 1'b0};
                if (sh_units_q == 4'd1) begin
                    // An odd final byte leaves the upper half unused.
                    if (sh_hi_q && (bytes_sent_q + 14'd1 != total_bytes)) begin
                        sh_hi_q <= 1'b0;
                        sh_byte_q <= sh_next_q;
                        sh_units_q <= units_per_byte(wmode);
                    end else begin
                        sh_busy_q <= 1'b0;
                    end
                end
            end
        end
    end

    // RAM-driver decode of CPU accesses into enables and strobes.
    logic seq_hit, rnd_hit, ram_hit, ram_acc;
    logic [1:0] drv_idx;
    assign seq_hit = (cpu_addr_i[23:3] == `SEQ_BASE_HI); // [R2]
    assign rnd_hit = (cpu_addr_i[23:18] == `RND_BASE_HI); // [R5]
    assign ram_hit = main_ctl_q[`DIRECT_RAM_BIT] ? rnd_hit : seq_hit; // [R6]
    assign drv_idx = main_ctl_q[`DIRECT_RAM_BIT] ? cpu_addr_i[17:16]
                                                 : cpu_addr_i[2:1]; // [R3]
    assign ram_acc = !sr_mode && ram_hit && (cpu_rd_i || cpu_wr_i);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            pins_q <= 4'h0;
            a0_q <= 1'b0;
            ext_rd_q <= 1'b0;
            ext_wr_q <= 1'b0;
        end else begin
            ext_rd_q <= ram_acc && cpu_rd_i; // [R4]
            ext_wr_q <= ram_acc && cpu_wr_i; // [R4]
            a0_q <= !main_ctl_q[`DIRECT_RAM_BIT] && cpu_addr_i[0]; // [R2]
            if (sr_mode) begin
                pins_q <= {cascade_lvl_q, frame_lvl_q, latch_lvl_q,
                           sh_clk_q}; // [R9]
            end else begin
                pins_q <= ram_acc ? (4'h1 << drv_idx) : 4'h0; // [R3]
            end
        end
    end

    assign reg_rdata_o = reg_rdata_q;
    assign bus_req_o = bus_req_q;
    assign mem_rd_o = mem_rd_q;
    assign mem_addr_o = mem_addr_q;
    assign lcd_data_o = sh_out_q;
    assign ext_rd_o = ext_rd_q;
    assign ext_wr_o = ext_wr_q;
    assign a0_o = a0_q;
    assign shift_clock_pin_o = pins_q[0];
    assign latch_pulse_pin_o = pins_q[1];
    assign frame_pin_o = pins_q[2];
    assign cascade_pin_o = pins_q[3];
    assign display_off_pin_o = main_ctl_q[`DISPLAY_ON_BIT]; // [R16]
endmodule // lcd_driver_controller

// *** rtl/lcd_cfg.svh ***
// Register map, field positions, reset values and address windows.
`ifndef LCD_CFG_SVH
`define LCD_CFG_SVH

`define REG_ADDR_W 12
`define OFS_START_LOW 12'h360
`define OFS_START_HIGH 12'h361
`define OFS_PANEL_SIZE 12'h362
`define OFS_MAIN_CTL 12'h363
`define OFS_FRAME_LOW 12'h364
`define OFS_SECOND_CTL 12'h366
`define OFS_CLK_STATUS 12'h367

`define RST_BYTE 8'h00
`define SECOND_CTL_FIXED 3'h7

`define MODE_SEL_BIT 0
`define START_BIT 0
`define FRAME_BIT8_BIT 1
`define DIRECT_RAM_BIT 2
`define WIDTH_LO_BIT 3
`define WIDTH_HI_BIT 4
`define DISPLAY_ON_BIT 7
`define RAM_WIDTH_BIT 2
`define TIMER_SEL_BIT 0
`define BUSY_BIT 1

`define SEQ_BASE_HI 21'h0001fc
`define RND_BASE_HI 6'h0f

`endif

// *** rtl/lcd_pkg.sv ***
// Types shared by the display controller modules.
package lcd_pkg;
    typedef enum logic [1:0] {
        WIDTH_BYTE,
        WIDTH_NIBBLE,
        WIDTH_BIT,
        WIDTH_RSVD
    } width_mode_t;

    typedef enum {
        XFER_IDLE,
        XFER_REQ,
        XFER_FETCH,
        XFER_WAIT,
        XFER_DRAIN
    } xfer_state_t;
endpackage

// *** rtl/fifo_if.sv ***
// Handshake bundle between the fetch logic, the FIFO and the shifter.
`timescale 1ns/1ps
interface fifo_if #(parameter int WIDTH = 16);
    logic [WIDTH-1:0] wdata;
    logic wvalid;
    logic wready;
    logic [WIDTH-1:0] rdata;
    logic rvalid;
    logic rready;

    modport fill (output wdata, output wvalid, input wready);
    modport drain (input rdata, input rvalid, output rready);
    modport buffer (input wdata, input wvalid, output wready,
                    output rdata, output rvalid, input rready);
endinterface // fifo_if

// *** rtl/lcd_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module lcd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic clk_i, // System clock.
    input wire logic resetn_i, // Synchronous reset, active low.
    fifo_if.buffer port_io // Fill and drain sides.
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] count_q;
    logic push;
    logic pop;

    assign port_io.wready = (count_q != (AW+1)'(DEPTH));
    assign port_io.rvalid = (count_q != '0);
    assign port_io.rdata = mem_q[rptr_q];
    assign push = port_io.wvalid && port_io.wready;
    assign pop = port_io.rvalid && port_io.rready;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wptr_q] <= port_io.wdata;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            wptr_q <= '0;
            rptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= (wptr_q == AW'(DEPTH - 1)) ? '0 : wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= (rptr_q == AW'(DEPTH - 1)) ? '0 : rptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule // lcd_fifo

// *** sim/lcd_mem_model.sv ***
// Source memory and bus grant model on the fetch side of the controller.
`timescale 1ns/1ps
module lcd_mem_model #(
    parameter int LAT = 3
) (
    input wire logic clk_i, // Clock.
    input wire logic bus_req_i, // Bus request.
    output logic bus_ack_o, // Bus grant.
    input wire logic [23:0] addr_i, // Read address.
    input wire logic rd_i, // Read pulse.
    output logic [15:0] data_o, // Read data.
    output logic valid_o // Data valid pulse.
);
    int wait_q = 0;
    logic [15:0] word_q = 16'h0;
    // Data lines show the inverse of the word outside valid.
    always @(posedge clk_i) begin
        bus_ack_o <= bus_req_i;
        valid_o <= (wait_q == 1);
        data_o <= (wait_q == 1) ? word_q : ~word_q;
        if (rd_i) begin
            wait_q <= LAT;
            word_q <= addr_i[15:0] ^ 16'h5a3c;
        end else if (wait_q > 0)
            wait_q <= wait_q - 1;
    end
endmodule // lcd_mem_model

// *** sim/lcd_driver_controller_props.sv ***
// Concurrent checks on the display controller ports.
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_driver_controller_props (
    input wire logic clk_i, // Clock.
    input wire logic resetn_i, // Reset.
    input wire logic [`REG_ADDR_W-1:0] reg_addr_i, // Address.
    input wire logic [7:0] reg_wdata_i, // Write data.
    input wire logic reg_wr_i, // Write.
    input wire logic [23:0] cpu_addr_i, // CPU address.
    input wire logic cpu_rd_i, // CPU read.
    input wire logic cpu_wr_i, // CPU write.
    input wire logic ext_rd_o, // Read strobe.
    input wire logic a0_o, // Select.
    input wire logic bus_req_o, // Bus request.
    input wire logic mem_rd_o, // Fetch.
    input wire logic shift_clock_pin_o, // Pin 1.
    input wire logic latch_pulse_pin_o, // Pin 2.
    input wire logic frame_pin_o, // Pin 3.
    input wire logic cascade_pin_o, // Pin 4.
    input wire logic display_off_pin_o // Display.
);
    logic sr_q, dir_q, go_q;
    wire [3:0] pins = {cascade_pin_o, frame_pin_o, latch_pulse_pin_o,
        shift_clock_pin_o};
    wire acc = cpu_rd_i | cpu_wr_i;
    wire seq_hit = acc && !dir_q && cpu_addr_i[23:3] == `SEQ_BASE_HI;
    wire rnd_hit = acc && dir_q && cpu_addr_i[23:18] == `RND_BASE_HI;
    // Mode bit shadows, from register writes.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sr_q <= 1'b0;
            dir_q <= 1'b0;
            go_q <= 1'b0;
        end else if (reg_wr_i && reg_addr_i == `OFS_START_LOW) begin
            sr_q <= reg_wdata_i[`MODE_SEL_BIT];
        end else if (reg_wr_i && reg_addr_i == `OFS_MAIN_CTL) begin
            dir_q <= reg_wdata_i[`DIRECT_RAM_BIT];
            go_q <= go_q | reg_wdata_i[`START_BIT];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    AST_NO_EARLY_REQ:
    assert property (!go_q |-> !bus_req_o) else $error("early bus request");
    AST_DISPLAY_OFF_PIN:
    assert property ((reg_wr_i && reg_addr_i == `OFS_MAIN_CTL) ##1 !reg_wr_i
        |=> display_off_pin_o == $past(reg_wdata_i[`DISPLAY_ON_BIT], 2))
        else $error("display pin wrong");
    AST_SEQ_MAP:
    assert property (seq_hit && !sr_q |=> pins == 4'h1 <<
        $past(cpu_addr_i[2:1]) && a0_o == $past(cpu_addr_i[0]))
        else $error("seq enable");
    AST_RND_MAP:
    assert property (rnd_hit && !sr_q |=> pins == 4'h1 <<
        $past(cpu_addr_i[17:16]) && !a0_o) else $error("rnd enable");
    AST_RAM_IDLE:
    assert property (!acc && !sr_q |=> pins == 4'h0)
        else $error("stray enable");
    AST_EXT_RD:
    assert property ((seq_hit || rnd_hit) && cpu_rd_i && !sr_q |=> ext_rd_o)
        else $error("no read strobe");
    AST_FETCH:
    assert property ($rose(mem_rd_o) |-> bus_req_o ##1 !mem_rd_o)
        else $error("fetch outside grant");
    AST_FRAME_FLIP:
    assert property (sr_q && $rose(cascade_pin_o) |->
        ##[0:2] frame_pin_o != $past(frame_pin_o, 3))
        else $error("no frame flip");
endmodule // lcd_driver_controller_props
bind lcd_driver_controller lcd_driver_controller_props props_i (.clk_i,
    .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .cpu_addr_i, .cpu_rd_i,
    .cpu_wr_i, .ext_rd_o, .a0_o, .bus_req_o, .mem_rd_o, .shift_clock_pin_o,
    .frame_pin_o, .latch_pulse_pin_o, .cascade_pin_o, .display_off_pin_o);

// *** sim/lcd_driver_controller_test.sv ***
// Self-checking bench for the display controller.
`timescale 1ns/1ps
`include "lcd_cfg.svh"
module lcd_driver_controller_test;
    logic clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic lcd_osc_i = 1'b0, cpu_rd_i = 1'b0, cpu_wr_i = 1'b0;
    logic [11:0] reg_addr_i = 12'h0;
    logic [7:0] reg_wdata_i = 8'h0;
    logic [23:0] cpu_addr_i = 24'h0;
    logic [1:0] div_q = 2'h0;
    wire [7:0] reg_rdata_o;
    wire [23:0] mem_addr_o;
    wire [15:0] mem_data_i;
    wire ext_rd_o, ext_wr_o, a0_o, bus_req_o, bus_ack_i, mem_rd_o;
    wire mem_valid_i, sc_o, lp_o, fr_o, cd_o, display_off_pin_o;
    wire [6:0] ram_view = {cd_o, fr_o, lp_o, sc_o, a0_o, ext_rd_o, ext_wr_o};
    int fail_count = 0, n_tests = 0;
    lcd_driver_controller dut (.clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .lcd_osc_i,
        .timer3_output_i(1'b0), .cpu_addr_i, .cpu_rd_i, .cpu_wr_i, .ext_rd_o,
        .ext_wr_o, .a0_o, .bus_req_o, .bus_ack_i, .mem_addr_o, .mem_rd_o,
        .mem_data_i, .mem_valid_i, .lcd_data_o(), .shift_clock_pin_o(sc_o),
        .latch_pulse_pin_o(lp_o), .frame_pin_o(fr_o), .cascade_pin_o(cd_o),
        .display_off_pin_o);
    lcd_mem_model mem (.clk_i, .bus_req_i(bus_req_o), .bus_ack_o(bus_ack_i),
        .addr_i(mem_addr_o), .rd_i(mem_rd_o), .data_o(mem_data_i),
        .valid_o(mem_valid_i));
    initial
        forever #50 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        div_q <= div_q + 2'h1;
        if (div_q == 2'h3)
            lcd_osc_i <= ~lcd_osc_i;
    end
    task automatic chk(input logic [31:0] got, exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: %h vs %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        @(posedge clk_i);
        chk(reg_rdata_o, exp);
    endtask
    task automatic cpu(input logic [23:0] a, input logic w);
        cpu_addr_i <= a;
        cpu_rd_i <= !w;
        cpu_wr_i <= w;
        @(posedge clk_i);
        cpu_rd_i <= 1'b0;
        cpu_wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_casc(output int k);
        logic p = 1'b1;
        for (k = 0; !(cd_o === 1'b1 && !p) && k < 9000; k++) begin
            p = cd_o;
            @(posedge clk_i);
        end
    endtask
    task automatic t_regs;
        chk(bus_req_o, 1'b0);
        rd(`OFS_MAIN_CTL, `RST_BYTE);
        rd(`OFS_CLK_STATUS, `RST_BYTE);
        wr(`OFS_FRAME_LOW, 8'ha5);
        wr(`OFS_SECOND_CTL, 8'he0);
        wr(`OFS_CLK_STATUS, 8'h03);
        rd(`OFS_FRAME_LOW, 8'ha5);
        rd(`OFS_SECOND_CTL, 8'he0);
        rd(`OFS_CLK_STATUS, 8'h01);
        rd(12'h100, 8'h00);
        wr(`OFS_CLK_STATUS, 8'h00);
        wr(`OFS_MAIN_CTL, 8'h80);
        chk(display_off_pin_o, 1'b1);
    endtask
    task automatic t_ram;
        logic [6:0] e;
        for (int i = 0; i < 8; i++) begin
            cpu(24'h000fe0 + 24'(i), !i[0]);
            e = {4'h1 << i[2:1], i[0], i[0], !i[0]};
            chk(ram_view, e);
        end
        wr(`OFS_MAIN_CTL, 8'h84);
        for (int i = 0; i < 4; i++) begin
            cpu({6'h0f, i[1:0], 16'h1234}, i[0]);
            e = {4'h1 << i[1:0], 1'b0, !i[0], i[0]};
            chk(ram_view, e);
        end
        cpu(24'h000fe1, 1'b1);
        chk(ram_view, 7'h00);
    endtask
    task automatic t_sr;
        int k, n = 0;
        logic p = 1'b0;
        wr(`OFS_START_LOW, 8'h01);
        wr(`OFS_START_HIGH, 8'h00);
        wr(`OFS_PANEL_SIZE, 8'h00);
        wr(`OFS_FRAME_LOW, 8'h40);
        wr(`OFS_MAIN_CTL, 8'h81);
        for (k = 0; bus_req_o !== 1'b1 && k < 9000; k++)
            @(posedge clk_i);
        chk(bus_req_o, 1'b1);
        for (; bus_req_o === 1'b1 && k < 20000; k++) begin
            @(posedge clk_i);
            if (sc_o === 1'b1 && !p) n++;
            p = sc_o;
        end
        chk(n, 256);
        chk(bus_req_o, 1'b0);
        wait_casc(k);
        wait_casc(k);
        chk(k, 3328);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #6000000;
        fail_count++;
        wrap_up;
    end
    initial begin
        repeat (3) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        t_regs;
        t_ram;
        t_sr;
        wrap_up;
    end
endmodule // lcd_driver_controller_test
